// ==== core/ufl_pkg.sv ====
// Shared constants for the flow-control, loopback and register-decode UART block
package ufl_pkg;
  // Register offsets on the three address lines
  localparam logic [2:0] OFS_DATA   = 3'h0;
  localparam logic [2:0] OFS_IEN    = 3'h1;
  localparam logic [2:0] OFS_ISTAT  = 3'h2;
  localparam logic [2:0] OFS_LCTRL  = 3'h3;
  localparam logic [2:0] OFS_MCTRL  = 3'h4;
  localparam logic [2:0] OFS_LSTAT  = 3'h5;
  localparam logic [2:0] OFS_MSTAT  = 3'h6;
  localparam logic [2:0] OFS_SCRACH = 3'h7;
  // Line control value that opens the enhanced bank
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
  // Field positions
  localparam int LCR_DLAB     = 7;
  localparam int LCR_BREAK    = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_ENH_EN   = 4;
  localparam int IER_CTS_EN   = 7;
  localparam int IER_RX_EN    = 0;
  localparam int MCR_LOOP     = 4;
  localparam int MCR_RTS      = 1;
  localparam int MCR_DTR      = 0;
  localparam int FEATURE_CONTROL_SEL     = 6;
  localparam int FCR_EN       = 0;
  localparam int FCR_RX_RST   = 1;
  localparam int FCR_TX_RST   = 2;
  localparam int ENHANCED_MODE_SELECT_HYST_LO = 4;
  // Pin positions in the synchroniser vector
  localparam int PIN_RX  = 0;
  localparam int PIN_CTS = 1;
  localparam int PIN_DSR = 2;
  localparam int PIN_CD  = 3;
  localparam int PIN_RI  = 4;
  localparam int PIN_N   = 5;
  // Reset values
  localparam logic [7:0] RX_TRIG_RST = 8'h08;
  localparam logic [7:0] REG_RST     = 8'h00;
  // Interrupt source codes in the low status nibble
  localparam logic [3:0] ISRC_NONE  = 4'h1;
  localparam logic [3:0] ISRC_RX    = 4'h4;
  localparam logic [3:0] ISRC_MODEM = 4'h0;
  // Serial timing at the 16x clock
  localparam logic [3:0] BIT_LAST    = 4'hf;
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] STOP_BIT    = 4'h9;
  localparam logic [7:0] HYST_STEP   = 8'h04;
endpackage

// ==== core/ufl_top.sv ====
// UART core: auto CTS/RTS flow control, internal loopback and banked register decode
//
// Contract
// - Gate transmitter on CTS only when auto-CTS set
// - CTS interrupt enable writable only with enhanced bit
// - CTS deassert under auto-CTS sets status bit 5
// - Finish current character through stop, start none
// - Resume pending transmit when CTS returns low
// - Interrupt at receive trigger, keep filling FIFO
// - Auto-RTS drives RTS high at upper threshold
// - Auto-RTS drives RTS low at lower threshold
// - Modem control bit 4 enables internal loopback
// - Loopback feeds transmit shifter into receiver
// - Loopback holds tx, RTS and DTR outputs, ignores modem inputs
// - No automatic flow control during loopback
// - Address lines decode only in parallel mode
// - Offset 0/1 bank by divisor latch bit
// - Zero divisor returns revision and identification codes
// - Offset 1 enable, offset 2 status/FIFO control
// - Fixed offsets for line, modem, status registers
// - Offset 7 scratch or level by feature bit
// - Enhanced bank at key value, upper offsets reserved
// - Auto-RTS needs enable bit and RTS asserted
`timescale 1ns/1ps
module ufl_top
  import ufl_pkg::*;
#(
  parameter int         DEPTH    = 64,
  parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h5a  // Arbitrary value
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // Host register port
  input  wire logic       parallel_mode_i,
  input  wire logic [2:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            int_o,
  // Serial and modem pins
  input  wire logic       rx_i,
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       cd_n_i,
  input  wire logic       ri_n_i,
  output logic            tx_o,
  output logic            rts_n_o,
  output logic            dtr_n_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [7:0] DEPTH8 = 8'(DEPTH);

  typedef struct packed {
    logic [PIN_N-1:0]       s1;
    logic [PIN_N-1:0]       s2;
    logic [PIN_N-1:0]       s3;
    logic [PIN_N-1:0]       pin_f;
    logic [7:0]             line_control;
    logic [7:0]             modem_control;
    logic [7:0]             interrupt_enable;
    logic [7:0]             enhanced_function;
    logic [7:0]             feature_control;
    logic [7:0]             dll;
    logic [7:0]             divisor_high;
    logic [7:0]             scratch_pad;
    logic [7:0]             enhanced_mode_select;
    logic [7:0]             trig;
    logic                   fifo_en;
    logic [7:0]             tx_holding;
    logic                   thr_full;
    logic                   tx_busy;
    logic [9:0]             tx_sh;
    logic [3:0]             tx_bit;
    logic [3:0]             tx_tick;
    logic                   rx_busy;
    logic [7:0]             rx_sh;
    logic [3:0]             rx_bit;
    logic [3:0]             rx_tick;
    logic [DEPTH-1:0][7:0]  mem;
    logic [AW-1:0]          wptr;
    logic [AW-1:0]          rptr;
    logic [CW-1:0]          cnt;
    logic                   rts_off;
    logic                   cts_int;
    logic                   dcts;
    logic [7:0]             rdata;
    logic                   irq;
    logic                   txp;
    logic                   rtsp;
    logic                   dtrp;
  } ufl_state_t;

  ufl_state_t st_r;
  ufl_state_t st_nxt;

  logic       loop_on;
  logic       enh_bank;
  logic       auto_cts;
  logic       auto_rts;
  logic       cts_off;
  logic       cts_rise;
  logic       txd;
  logic       rx_src;
  logic [7:0] cnt8;
  logic [7:0] hyst;
  logic [7:0] upper;
  logic [7:0] lower;
  logic       rx_int;
  logic       acc_wr;
  logic       acc_rd;
  logic       tx_may_start;

  // Host strobes count only in parallel mode
  assign acc_wr   = wr_i & parallel_mode_i;
  assign acc_rd   = rd_i & parallel_mode_i;
  assign loop_on  = st_r.modem_control[MCR_LOOP];
  assign enh_bank = (st_r.line_control == LCR_ENH_KEY);
  // Flow control switched off in loopback
  assign auto_cts = st_r.enhanced_function[EFR_AUTO_CTS] & ~loop_on;
  assign auto_rts = st_r.enhanced_function[EFR_AUTO_RTS] & st_r.modem_control[MCR_RTS] & ~loop_on;
  assign cts_off  = st_r.pin_f[PIN_CTS];
  // Filtered CTS about to go high; filter only trusts agreeing stages
  assign cts_rise = (st_r.s2[PIN_CTS] == st_r.s3[PIN_CTS]) & st_r.s3[PIN_CTS]
                    & ~cts_off & ~loop_on;
  assign txd      = st_r.line_control[LCR_BREAK] ? 1'b0 : (st_r.tx_busy ? st_r.tx_sh[0] : 1'b1);
  assign rx_src   = loop_on ? txd : st_r.pin_f[PIN_RX];
  assign cnt8     = 8'(st_r.cnt);
  // Hysteresis band is 4, 8, 12 or 16 around the trigger
  assign hyst     = {2'b00, st_r.enhanced_mode_select[ENHANCED_MODE_SELECT_HYST_LO+1:ENHANCED_MODE_SELECT_HYST_LO], 2'b00} + HYST_STEP;
  assign upper    = (st_r.trig > DEPTH8 - hyst) ? DEPTH8 : st_r.trig + hyst;
  assign lower    = (st_r.trig > hyst) ? st_r.trig - hyst : 8'h00;
  assign rx_int   = st_r.interrupt_enable[IER_RX_EN] & (st_r.cnt != '0) & (cnt8 >= st_r.trig);
  assign tx_may_start = ~(auto_cts & cts_off);

  // Next-state logic for the whole block
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop  = 1'b0;
    st_nxt = st_r;

    // Three-stage pin synchroniser; modem inputs frozen in loopback
    st_nxt.s1 = {ri_n_i, cd_n_i, dsr_n_i, cts_n_i, rx_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < PIN_N; i++) begin
      if (st_r.s2[i] == st_r.s3[i] && !(loop_on && i != PIN_RX)) begin
        st_nxt.pin_f[i] = st_r.s3[i];
      end
    end

    // Host reads; the answer lands one cycle after the strobe
    if (acc_rd) begin
      unique case (addr_i)
        OFS_DATA: begin
          if (enh_bank) begin
            st_nxt.rdata = cnt8;
          end else if (st_r.line_control[LCR_DLAB]) begin
            st_nxt.rdata = (st_r.dll == 8'h00 && st_r.divisor_high == 8'h00) ? REV_CODE
                                                                   : st_r.dll;
          end else begin
            st_nxt.rdata = st_r.mem[st_r.rptr];
            pop = (st_r.cnt != '0);
          end
        end
        OFS_IEN: begin
          if (enh_bank) begin
            st_nxt.rdata = st_r.feature_control;
          end else if (st_r.line_control[LCR_DLAB]) begin
            st_nxt.rdata = (st_r.dll == 8'h00 && st_r.divisor_high == 8'h00) ? DEV_ID
                                                                   : st_r.divisor_high;
          end else begin
            st_nxt.rdata = st_r.interrupt_enable;
          end
        end
        OFS_ISTAT: begin
          if (enh_bank) begin
            st_nxt.rdata = st_r.enhanced_function;
          end else begin
            st_nxt.rdata = {st_r.fifo_en, st_r.fifo_en, st_r.cts_int, 1'b0,
                            rx_int ? ISRC_RX :
                            (st_r.cts_int & st_r.interrupt_enable[IER_CTS_EN]) ? ISRC_MODEM
                                                                  : ISRC_NONE};
            st_nxt.cts_int = 1'b0;
          end
        end
        OFS_LCTRL:  st_nxt.rdata = st_r.line_control;
        OFS_MCTRL:  st_nxt.rdata = enh_bank ? REG_RST : st_r.modem_control;
        OFS_LSTAT: begin
          st_nxt.rdata = enh_bank ? REG_RST :
                         {1'b0, ~st_r.tx_busy & ~st_r.thr_full, ~st_r.thr_full,
                          4'h0, st_r.cnt != '0};
        end
        OFS_MSTAT: begin
          st_nxt.rdata = enh_bank ? REG_RST :
                         {~st_r.pin_f[PIN_CD], ~st_r.pin_f[PIN_RI], ~st_r.pin_f[PIN_DSR],
                          ~cts_off, 3'h0, st_r.dcts};
          if (!enh_bank) begin
            st_nxt.dcts = 1'b0;
          end
        end
        OFS_SCRACH: begin
          st_nxt.rdata = enh_bank ? REG_RST :
                         (st_r.feature_control[FEATURE_CONTROL_SEL] ? cnt8 : st_r.scratch_pad);
        end
      endcase
    end

    // Host writes
    if (acc_wr) begin
      unique case (addr_i)
        OFS_DATA: begin
          if (enh_bank) begin
            st_nxt.trig = wdata_i;
          end else if (st_r.line_control[LCR_DLAB]) begin
            st_nxt.dll = wdata_i;
          end else begin
            st_nxt.tx_holding      = wdata_i;
            st_nxt.thr_full = 1'b1;
          end
        end
        OFS_IEN: begin
          if (enh_bank) begin
            st_nxt.feature_control = wdata_i;
          end else if (st_r.line_control[LCR_DLAB]) begin
            st_nxt.divisor_high = wdata_i;
          end else begin
            // Upper enables stay locked until the enhanced bit opens them
            st_nxt.interrupt_enable[3:0] = wdata_i[3:0];
            if (st_r.enhanced_function[EFR_ENH_EN]) begin
              st_nxt.interrupt_enable[7:4] = wdata_i[7:4];
            end
          end
        end
        OFS_ISTAT: begin
          if (enh_bank) begin
            st_nxt.enhanced_function = wdata_i;
          end else begin
            st_nxt.fifo_en = wdata_i[FCR_EN];
            if (wdata_i[FCR_TX_RST]) begin
              st_nxt.thr_full = 1'b0;
            end
          end
        end
        OFS_LCTRL: st_nxt.line_control = wdata_i;
        OFS_MCTRL: begin
          if (!enh_bank) begin
            st_nxt.modem_control = wdata_i;
          end
        end
        OFS_SCRACH: begin
          if (!enh_bank && st_r.feature_control[FEATURE_CONTROL_SEL]) begin
            st_nxt.enhanced_mode_select = wdata_i;
          end else if (!enh_bank) begin
            st_nxt.scratch_pad = wdata_i;
          end
        end
        default: ;
      endcase
    end

    // Transmitter: a new frame only starts while CTS allows it
    if (!st_r.tx_busy) begin
      if (st_r.thr_full && tx_may_start) begin
        st_nxt.tx_sh    = {1'b1, st_r.tx_holding, 1'b0};
        st_nxt.tx_busy  = 1'b1;
        st_nxt.tx_bit   = 4'h0;
        st_nxt.tx_tick  = 4'h0;
        st_nxt.thr_full = acc_wr && addr_i == OFS_DATA && !enh_bank && !st_r.line_control[LCR_DLAB];
      end
    end else begin
      // CTS is not looked at mid-frame, so the stop bit always goes out
      st_nxt.tx_tick = st_r.tx_tick + 4'h1;
      if (st_r.tx_tick == BIT_LAST) begin
        st_nxt.tx_sh  = {1'b1, st_r.tx_sh[9:1]};
        st_nxt.tx_bit = st_r.tx_bit + 4'h1;
        if (st_r.tx_bit == STOP_BIT) begin
          st_nxt.tx_busy = 1'b0;
        end
      end
    end

    // Receiver samples each bit in its middle
    if (!st_r.rx_busy) begin
      if (!rx_src) begin
        st_nxt.rx_busy = 1'b1;
        st_nxt.rx_tick = 4'h0;
        st_nxt.rx_bit  = 4'h0;
      end
    end else begin
      st_nxt.rx_tick = st_r.rx_tick + 4'h1;
      if (st_r.rx_tick == SAMPLE_TICK) begin
        if (st_r.rx_bit == 4'h0 && rx_src) begin
          st_nxt.rx_busy = 1'b0;
        end else if (st_r.rx_bit == STOP_BIT) begin
          st_nxt.rx_busy = 1'b0;
          // Past the trigger the FIFO keeps filling; only a full one or a low stop bit drops
          push = rx_src && (cnt8 < DEPTH8);
        end else if (st_r.rx_bit != 4'h0) begin
          st_nxt.rx_sh = {rx_src, st_r.rx_sh[7:1]};
        end
      end
      if (st_r.rx_tick == BIT_LAST) begin
        st_nxt.rx_bit = st_r.rx_bit + 4'h1;
      end
    end

    // Receive FIFO pointers
    if (push) begin
      st_nxt.mem[st_r.wptr] = st_r.rx_sh;
      st_nxt.wptr = st_r.wptr + AW'(1);
    end
    if (pop) begin
      st_nxt.rptr = st_r.rptr + AW'(1);
    end
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
    if (acc_wr && addr_i == OFS_ISTAT && !enh_bank && wdata_i[FCR_RX_RST]) begin
      st_nxt.wptr = '0;
      st_nxt.rptr = '0;
      st_nxt.cnt  = '0;
    end

    // RTS hysteresis: off at the upper threshold, back on at the lower
    if (!auto_rts) begin
      st_nxt.rts_off = 1'b0;
    end else if (cnt8 >= upper) begin
      st_nxt.rts_off = 1'b1;
    end else if (cnt8 <= lower) begin
      st_nxt.rts_off = 1'b0;
    end

    // Modem delta and CTS interrupt; a set beats a same-cycle clear
    if (cts_rise || ((st_r.s2[PIN_CTS] == st_r.s3[PIN_CTS]) &&
                     st_r.s3[PIN_CTS] != cts_off && !loop_on)) begin
      st_nxt.dcts = 1'b1;
    end
    if (cts_rise && auto_cts && st_r.interrupt_enable[IER_CTS_EN]) begin
      st_nxt.cts_int = 1'b1;
    end

    // Pin drivers; loopback freezes tx, RTS and DTR at their last level, not the interrupt
    st_nxt.irq  = rx_int | (st_r.interrupt_enable[IER_CTS_EN] & st_r.cts_int);
    st_nxt.txp  = loop_on ? st_r.txp : txd;
    st_nxt.rtsp = loop_on ? st_r.rtsp
                          : (auto_rts ? st_r.rts_off : ~st_r.modem_control[MCR_RTS]);
    st_nxt.dtrp = loop_on ? st_r.dtrp : ~st_r.modem_control[MCR_DTR];
  end

  // State register; pins idle high, receive trigger at its default
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r       <= '0;
      st_r.s1    <= '1;
      st_r.s2    <= '1;
      st_r.s3    <= '1;
      st_r.pin_f <= '1;
      st_r.trig  <= RX_TRIG_RST;
      st_r.tx_sh <= '1;
      st_r.txp   <= 1'b1;
      st_r.rtsp  <= 1'b1;
      st_r.dtrp  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign int_o   = st_r.irq;
  assign tx_o    = st_r.txp;
  assign rts_n_o = st_r.rtsp;
  assign dtr_n_o = st_r.dtrp;

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_tx_blocked;
    !st_r.tx_busy && auto_cts && cts_off;
  endsequence
  sequence s_tx_ready;
    !st_r.tx_busy && st_r.thr_full && (!auto_cts || !cts_off);
  endsequence

  a_cts_gate_hold: assert property (s_tx_blocked |=> !st_r.tx_busy)
    else $error("frame started while CTS held it off");
  a_ier_lock_bits: assert property (acc_wr && addr_i == OFS_IEN && !enh_bank
      && !st_r.line_control[LCR_DLAB] && !st_r.enhanced_function[EFR_ENH_EN] |=> $stable(st_r.interrupt_enable[7:4]))
    else $error("upper enable bits written without enhanced bit");
  a_cts_int_raise: assert property (cts_rise && auto_cts && st_r.interrupt_enable[IER_CTS_EN]
      |=> st_r.cts_int ##1 int_o)
    else $error("CTS deassertion did not raise interrupt");
  a_tx_stop_done: assert property ($fell(st_r.tx_busy) |-> $past(st_r.tx_bit) == STOP_BIT
      && st_r.tx_bit == 4'ha)
    else $error("frame ended before its stop bit");
  a_cts_resume_tx: assert property (s_tx_ready |=> st_r.tx_busy)
    else $error("pending data not sent with CTS clear");
  a_rx_trig_int: assert property (rx_int |=> int_o)
    else $error("trigger level reached without interrupt");
  a_rts_upper_off: assert property (auto_rts && cnt8 >= upper ##1 auto_rts
      |=> rts_n_o)
    else $error("RTS not deasserted at upper threshold");
  a_rts_lower_on: assert property (auto_rts && cnt8 <= lower ##1 auto_rts && cnt8 <= lower
      |=> !rts_n_o)
    else $error("RTS not reasserted at lower threshold");
  a_loop_rx_path: assert property (loop_on && $rose(st_r.tx_busy) && !st_r.rx_busy
      && !st_r.line_control[LCR_BREAK] |=> st_r.rx_busy)
    else $error("looped transmit start not seen by receiver");
  a_loop_pins_hold: assert property (loop_on |=> $stable(tx_o) && $stable(rts_n_o)
      && $stable(dtr_n_o))
    else $error("pin moved during loopback");
  a_serial_no_write: assert property (wr_i && !parallel_mode_i && addr_i == OFS_LCTRL
      |=> $stable(st_r.line_control))
    else $error("register written outside parallel mode");
  a_zero_div_id: assert property (acc_rd && addr_i == OFS_DATA && st_r.line_control[LCR_DLAB]
      && !enh_bank && st_r.dll == 8'h00 && st_r.divisor_high == 8'h00 |=> rdata_o == REV_CODE)
    else $error("revision code not returned");
endmodule

// ==== tb/ufl_remote.sv ====
// Remote UART model: flow-gated transmitter and receiver of our serial output
`timescale 1ns/1ps
module ufl_remote (
  // Clock of the bench
  input  wire logic clk_i,
  // Modem and serial lines
  input  wire logic cts_n_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [7:0] sb;
  logic [7:0] rb;

  // Frames start only with clear-to-send low; a started frame always completes
  initial begin
    line_o = 1'b1; // Idle high, also through loopback
    forever begin
      @(negedge clk_i);
      if (send_q.size() > 0 && !cts_n_i) begin
        sb = send_q.pop_front();
        line_o = 1'b0;
        repeat (16) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
          line_o = sb[i];
          repeat (16) @(negedge clk_i);
        end
        line_o = 1'b1;
        repeat (16) @(negedge clk_i);
      end
    end
  end

  // Mid-bit sampling, LSB first
  initial forever begin
    @(negedge line_i);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_i);
      rb[i] = line_i;
    end
    repeat (16) @(posedge clk_i);
    got_q.push_back(rb);
  end
endmodule

// ==== tb/tb_ufl_top.sv ====
// Self-checking bench for the flow-control, loopback and decode UART block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_ufl_top;
  import ufl_pkg::*;
  localparam logic [7:0] REV = 8'h21; // Arbitrary value
  localparam logic [7:0] DID = 8'h6c; // Arbitrary value
  logic       core_clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       parallel_mode_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic       rx_i;
  logic       cts_n_i = 1'b0;
  logic       dsr_n_i = 1'b1;
  logic       cd_n_i = 1'b1;
  logic       ri_n_i = 1'b1;
  logic [7:0] rdata_o;
  logic       int_o;
  logic       tx_o;
  logic       rts_n_o;
  logic       dtr_n_o;
  logic       loop_on = 1'b0;
  logic       tx_seen = 1'b0;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int         fails = 0;
  int         tests_run = 0;

  ufl_top #(.DEPTH(64), .REV_CODE(REV), .DEV_ID(DID)) dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .parallel_mode_i(parallel_mode_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .int_o(int_o), .rx_i(rx_i), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i), .cd_n_i(cd_n_i),
    .ri_n_i(ri_n_i), .tx_o(tx_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o)
  );
  // Remote party sees our request-to-send as its clear-to-send
  ufl_remote rem (.clk_i(core_clk_i), .cts_n_i(rts_n_o), .line_i(tx_o), .line_o(rx_i));

  initial forever #4 core_clk_i = ~core_clk_i;

  // Serial output must stay idle while looped back; looked at once settled
  always @(negedge core_clk_i) if (loop_on && tx_o !== 1'b1) tx_seen <= 1'b1;

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Host strobes change at the falling edge, one access per call
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge core_clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge core_clk_i);
    rd_i = 1'b0;
    d = rdata_o;
  endtask
  task automatic crd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs about 5k cycles
  initial begin
    repeat (40000) @(posedge core_clk_i);
    fails++;
    conclude();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] s;
    s = 8'h5d;
    repeat (5) @(negedge core_clk_i);
    reset_i = 1'b0;
    `CHK({tx_o, rts_n_o, dtr_n_o, int_o}, 4'he)
    // Bank decode, refused accesses, reserved space
    wr(OFS_LCTRL, 8'h03);
    crd(OFS_LCTRL, 8'h03);
    wr(OFS_MCTRL, 8'h01);
    crd(OFS_MCTRL, 8'h01);
    wr(OFS_SCRACH, 8'ha5);
    crd(OFS_SCRACH, 8'ha5);
    parallel_mode_i = 1'b0;
    wr(OFS_SCRACH, 8'h3c);
    wr(OFS_LCTRL, LCR_ENH_KEY);
    parallel_mode_i = 1'b1;
    crd(OFS_SCRACH, 8'ha5);
    crd(OFS_LCTRL, 8'h03);
    wr(OFS_IEN, 8'h81);
    crd(OFS_IEN, 8'h01);
    wr(OFS_LCTRL, 8'h83);
    crd(OFS_DATA, REV);
    crd(OFS_IEN, DID);
    wr(OFS_DATA, 8'h34);
    crd(OFS_DATA, 8'h34);
    wr(OFS_DATA, 8'h00);
    wr(OFS_LCTRL, LCR_ENH_KEY);
    wr(OFS_IEN, 8'h40);
    crd(OFS_IEN, 8'h40);
    crd(OFS_MCTRL, 8'h00);
    wr(OFS_ISTAT, 8'h90);
    crd(OFS_ISTAT, 8'h90);
    wr(OFS_LCTRL, 8'h03);
    wr(OFS_IEN, 8'h80);
    crd(OFS_IEN, 8'h80);
    wr(OFS_ISTAT, 8'h01);
    crd(OFS_SCRACH, 8'h00);
    crd(OFS_LSTAT, 8'h60);
    // Modem inputs show inverted; first read only clears the delta bit
    dsr_n_i = 1'b0;
    cd_n_i = 1'b0;
    wt(6);
    rd(OFS_MSTAT, d);
    crd(OFS_MSTAT, 8'hb0);
    $display("test decode done");
    // Auto CTS: stop after the running frame, interrupt, resume
    s = lfsr(s);
    txq.push_back(s);
    wr(OFS_DATA, s);
    for (int i = 0; i < 20 && tx_o !== 1'b0; i++) wt(1);
    cts_n_i = 1'b1;
    s = lfsr(s);
    txq.push_back(s);
    wr(OFS_DATA, s);
    wt(400);
    `CHK(rem.got_q.size(), 1)
    `CHK(int_o, 1'b1)
    crd(OFS_ISTAT, {4'he, ISRC_MODEM});
    wt(2);
    `CHK(int_o, 1'b0)
    cts_n_i = 1'b0;
    wt(400);
    `CHK(rem.got_q.size(), 2)
    while (txq.size() > 0) begin
      d = rem.got_q.pop_front();
      e = txq.pop_front();
      `CHK(d, e)
    end
    $display("test auto cts done");
    // Auto RTS: stall remote at upper mark, release at lower mark
    wr(OFS_LCTRL, LCR_ENH_KEY);
    wr(OFS_ISTAT, 8'h50);
    wr(OFS_LCTRL, 8'h03);
    wr(OFS_IEN, 8'h01);
    wr(OFS_MCTRL, 8'h03);
    wt(4);
    `CHK(rts_n_o, 1'b0)
    repeat (16) begin
      s = lfsr(s);
      rxq.push_back(s);
      rem.send_q.push_back(s);
    end
    for (int i = 0; i < 4000 && rts_n_o !== 1'b1; i++) wt(1);
    wt(400);
    `CHK(rts_n_o, 1'b1)
    `CHK(int_o, 1'b1)
    wr(OFS_LCTRL, LCR_ENH_KEY);
    rd(OFS_DATA, d);
    wr(OFS_LCTRL, 8'h03);
    `CHK(d >= 8'd12 && d <= 8'd13, 1'b1)
    repeat (d - 8'd4) crd(OFS_DATA, rxq.pop_front());
    wt(4);
    `CHK(rts_n_o, 1'b0)
    wt(1000);
    while (rxq.size() > 0) crd(OFS_DATA, rxq.pop_front());
    $display("test auto rts done");
    // Loopback with flow control armed and clear-to-send deasserted
    wr(OFS_MCTRL, 8'h13);
    loop_on = 1'b1;
    wr(OFS_LCTRL, LCR_ENH_KEY);
    wr(OFS_ISTAT, 8'hd0);
    wr(OFS_LCTRL, 8'h03);
    cts_n_i = 1'b1;
    dsr_n_i = 1'b1;
    cd_n_i = 1'b1;
    s = lfsr(s);
    wr(OFS_DATA, s);
    wt(400);
    crd(OFS_DATA, s);
    // Modem inputs frozen: delta left from the CTS test, then cleared
    crd(OFS_MSTAT, 8'hb1);
    crd(OFS_MSTAT, 8'hb0);
    `CHK({rts_n_o, dtr_n_o, tx_seen}, 3'b000)
    `CHK(rem.got_q.size(), 0)
    $display("test loopback done");
    conclude();
  end
endmodule
